// *** hdl/bit_sync.sv ***
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bit_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Level in and out
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1; // First flop, read only by the second
	logic next_stage1;
	logic next_syncOut;

	// Next values
	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	// Registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule : bit_sync

// *** hdl/pclk_prescaler.sv ***
// Power-of-two prescaler making the divided VCO clock from the sampled VCO level
`timescale 1ns/1ps
module pclk_prescaler (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Sampled VCO level and division power
	input wire logic vcoLevel,
	input wire logic [1:0] pre,
	// Divided clock level and its rising-edge pulse
	output logic pclkLevel,
	output logic pclkRise
);
	logic vcoPrev; // VCO level one cycle ago
	logic [2:0] count; // VCO rising edges seen
	logic next_vcoPrev;
	logic [2:0] next_count;
	logic next_pclkLevel;
	logic next_pclkRise;

	// Count VCO edges and pick the tap for 1, 2, 4 or 8
	always_comb begin
		next_vcoPrev = vcoLevel;
		next_count = count;
		if (vcoLevel && !vcoPrev) begin
			next_count = count + 3'h1;
		end
		unique case (pre)
			2'h0: next_pclkLevel = vcoLevel;
			2'h1: next_pclkLevel = count[0];
			2'h2: next_pclkLevel = count[1];
			2'h3: next_pclkLevel = count[2];
		endcase
		next_pclkRise = next_pclkLevel && !pclkLevel;
	end

	// Registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vcoPrev <= 1'b0;
			count <= 3'h0;
			pclkLevel <= 1'b0;
			pclkRise <= 1'b0;
		end else begin
			vcoPrev <= next_vcoPrev;
			count <= next_count;
			pclkLevel <= next_pclkLevel;
			pclkRise <= next_pclkRise;
		end
	end
endmodule : pclk_prescaler

// *** hdl/pll_base_clock_selector.sv ***
// PLL programming registers, base clock selector and lock interrupt behind APB
//
// Notes on behaviour
// - Divider fields writable only while PLL off
// - Zero R or N acts as one
// - Zero L disables PLL, forces oscillator
// - Switch waits three edges each, output held
// - Switched clock is halved
// - Bypass skips halving on oscillator path
// - No VCO select while PLL off
// - PLL cannot stop while VCO selected
// - Run and select change in separate writes
// - Base output fifty percent duty
// - Interrupt driven from lock detector and switch completion
// - Reference clock buffers oscillator clock
// - Centre frequency is L times 2^E times step
// - Select bit picks divided VCO or oscillator
// - Lock toggle sets flag, control read clears
// - Prescaler code divides by 1, 2, 4, 8
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pll_clock_regs.svh"
module pll_base_clock_selector (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clocks and lock level from the analog side
	input wire logic osc_clock,
	input wire logic vco_clock,
	input wire logic lockDetect,
	// Clock outputs
	output logic base_clock_out,
	output logic pll_reference_clock,
	// Effective settings towards the PLL
	output logic pllEnable,
	output logic [1:0] prescaler,
	output logic [1:0] vcoRangePower,
	output logic [11:0] multiplier,
	output logic [7:0] linearRange,
	output logic [3:0] refDivider,
	output logic [31:0] vcoCentreHz,
	// Interrupt
	output logic pll_lock_interrupt
);
	// ==========================================================
	// Declarations
	logic oscSync, vcoSync, lockSync; // Sampled pin levels
	logic pclkLevel, pclkRise; // Divided VCO clock
	logic pllRun, baseSel; // Run and select bits
	logic [1:0] pre, vco_range_power_field; // P and E
	logic [7:0] mulLow; // N low byte
	logic [3:0] mulHigh; // N high nibble
	logic [7:0] lrange; // L
	logic [3:0] rdiv; // R
	logic bypass; // Oscillator halving bypass
	logic [1:0] irqEn, status; // Interrupt enable and sticky status
	logic lockPrev; // Lock level one cycle ago
	logic next_pllRun, next_baseSel, next_bypass, next_lockPrev;
	logic [1:0] next_pre, next_vpr, next_irqEn, next_status, clrBits;
	logic [7:0] next_mulLow, next_lrange;
	logic [3:0] next_mulHigh, next_rdiv;
	logic wrAcc, rdAcc, setupPh; // Bus phases
	logic reqRun, reqSel, runChg, selChg, lockToggle, lZero;
	logic [11:0] effN; // N after zero fix
	logic [3:0] effR; // R after zero fix
	logic [31:0] rdMux;
	logic mapped;
	pll_clock_pkg::switch_state_t swState, next_swState;
	pll_clock_pkg::clk_src_t activeSrc, reqSrc, next_activeSrc;
	logic [1:0] oscCnt, pclkCnt, next_oscCnt, next_pclkCnt;
	logic oscPrev, next_oscPrev, oscRise, switchDone, next_baseOut;

	// ==========================================================
	// Pin synchronisers
	bit_sync u_oscSync (.clk(clk), .sys_rst(sys_rst), .asyncIn(osc_clock), .syncOut(oscSync));
	bit_sync u_vcoSync (.clk(clk), .sys_rst(sys_rst), .asyncIn(vco_clock), .syncOut(vcoSync));
	bit_sync u_lockSync (.clk(clk), .sys_rst(sys_rst), .asyncIn(lockDetect), .syncOut(lockSync));

	// Divided VCO clock
	pclk_prescaler u_prescaler (
		.clk(clk),
		.sys_rst(sys_rst),
		.vcoLevel(vcoSync),
		.pre(pre),
		.pclkLevel(pclkLevel),
		.pclkRise(pclkRise)
	);

	// ==========================================================
	// Bus decode and derived values
	always_comb begin
		setupPh = psel && !penable;
		wrAcc = psel && penable && pready && pwrite;
		rdAcc = psel && penable && pready && !pwrite;
		reqRun = pwdata[`PCR_RUN_BIT];
		reqSel = pwdata[`PCR_SEL_BIT];
		runChg = reqRun != pllRun;
		selChg = reqSel != baseSel;
		lockToggle = lockSync != lockPrev;
		lZero = lrange == 8'h00;
		// Zero N or R behaves as one
		effN = ({mulHigh, mulLow} == 12'h000) ? `ONE_N : {mulHigh, mulLow};
		effR = (rdiv == 4'h0) ? `ONE_R : rdiv;
		reqSrc = (baseSel && pllRun && !lZero) ? pll_clock_pkg::SRC_PCLK
			: pll_clock_pkg::SRC_OSC;
	end

	// Read data and address map
	always_comb begin
		rdMux = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			`PCR_OFFSET: begin
				rdMux[`PCR_FLAG_BIT] = status[`IRQ_LOCK_BIT];
				rdMux[`PCR_RUN_BIT] = pllRun;
				rdMux[`PCR_SEL_BIT] = baseSel;
				rdMux[`PCR_PRE_MSB:`PCR_PRE_LSB] = pre;
				rdMux[`PCR_VPR_MSB:`PCR_VPR_LSB] = vco_range_power_field;
			end
			`MULLO_OFFSET: rdMux[7:0] = mulLow;
			`MULHI_OFFSET: rdMux[3:0] = mulHigh;
			`LRANGE_OFFSET: rdMux[7:0] = lrange;
			`RDIV_OFFSET: rdMux[3:0] = rdiv;
			`OPT2_OFFSET: rdMux[`OPT2_BYPASS_BIT] = bypass;
			`IRQST_OFFSET: rdMux[1:0] = status;
			`IRQEN_OFFSET: rdMux[1:0] = irqEn;
			`IRQCLR_OFFSET: rdMux = 32'h0000_0000;
			`STATE_OFFSET: rdMux[3:0] = {pllEnable, activeSrc, swState, lockSync};
			`EFFDIV_OFFSET: rdMux = {4'h0, effN, 12'h000, effR};
			default: mapped = 1'b0;
		endcase
	end

	// ==========================================================
	// Register file next values
	always_comb begin
		next_pllRun = pllRun;
		next_baseSel = baseSel;
		next_pre = pre;
		next_vpr = vco_range_power_field;
		next_mulLow = mulLow;
		next_mulHigh = mulHigh;
		next_lrange = lrange;
		next_rdiv = rdiv;
		next_bypass = bypass;
		next_irqEn = irqEn;
		next_lockPrev = lockSync;
		clrBits = 2'h0;
		if (wrAcc) begin
			case (paddr)
				`PCR_OFFSET: begin
					if (!pllRun) begin
						next_pre = pwdata[`PCR_PRE_MSB:`PCR_PRE_LSB];
						next_vpr = pwdata[`PCR_VPR_MSB:`PCR_VPR_LSB];
					end
					// Both changing in one write is ignored
					if (!(runChg && selChg)) begin
						if (runChg && !(baseSel && !reqRun)) begin
							next_pllRun = reqRun;
						end
						// Refuse select while PLL off or L zero
						if (selChg && !(reqSel && (!pllRun || lZero))) begin
							next_baseSel = reqSel;
						end
					end
				end
				`MULLO_OFFSET: if (!pllRun) next_mulLow = pwdata[7:0];
				`MULHI_OFFSET: if (!pllRun) next_mulHigh = pwdata[3:0];
				`LRANGE_OFFSET: if (!pllRun) next_lrange = pwdata[7:0];
				`RDIV_OFFSET: if (!pllRun) next_rdiv = pwdata[3:0];
				`OPT2_OFFSET: next_bypass = pwdata[`OPT2_BYPASS_BIT];
				`IRQEN_OFFSET: next_irqEn = pwdata[1:0];
				`IRQCLR_OFFSET: clrBits = pwdata[1:0];
				default: clrBits = 2'h0;
			endcase
		end
		// Control read clears the lock flag
		if (rdAcc && paddr == `PCR_OFFSET) begin
			clrBits[`IRQ_LOCK_BIT] = 1'b1;
		end
		// Set wins over clear
		next_status = (status & ~clrBits) | {switchDone, lockToggle};
	end

	// Register file flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pllRun <= 1'b1;
			baseSel <= 1'b0;
			pre <= 2'h0;
			vco_range_power_field <= 2'h0;
			mulLow <= 8'(`MUL_RESET);
			mulHigh <= 4'(`MUL_RESET >> 8);
			lrange <= `LRANGE_RESET;
			rdiv <= `RDIV_RESET;
			bypass <= 1'b0;
			irqEn <= 2'h0;
			status <= 2'h0;
			lockPrev <= 1'b0;
		end else begin
			pllRun <= next_pllRun;
			baseSel <= next_baseSel;
			pre <= next_pre;
			vco_range_power_field <= next_vpr;
			mulLow <= next_mulLow;
			mulHigh <= next_mulHigh;
			lrange <= next_lrange;
			rdiv <= next_rdiv;
			bypass <= next_bypass;
			irqEn <= next_irqEn;
			status <= next_status;
			lockPrev <= next_lockPrev;
		end
	end

	// ==========================================================
	// Source switch sequencer and output divider
	always_comb begin
		next_swState = swState;
		next_activeSrc = activeSrc;
		next_oscCnt = oscCnt;
		next_pclkCnt = pclkCnt;
		next_oscPrev = oscSync;
		next_baseOut = base_clock_out;
		oscRise = oscSync && !oscPrev;
		switchDone = 1'b0;
		unique case (swState)
			pll_clock_pkg::SW_RUN: begin
				if (reqSrc != activeSrc) begin
					next_swState = pll_clock_pkg::SW_HOLD;
					next_oscCnt = 2'h0;
					next_pclkCnt = 2'h0;
				end else if (activeSrc == pll_clock_pkg::SRC_OSC && bypass) begin
					next_baseOut = oscSync;
				end else if (activeSrc == pll_clock_pkg::SRC_OSC ? oscRise : pclkRise) begin
					// Toggle on each source rise, halving with even duty
					next_baseOut = !base_clock_out;
				end
			end
			pll_clock_pkg::SW_HOLD: begin
				// Count three edges of each clock, output held
				if (oscRise && oscCnt != `SWITCH_EDGES) next_oscCnt = oscCnt + 2'h1;
				if (pclkRise && pclkCnt != `SWITCH_EDGES) next_pclkCnt = pclkCnt + 2'h1;
				if (oscCnt == `SWITCH_EDGES && pclkCnt == `SWITCH_EDGES) begin
					next_activeSrc = reqSrc;
					next_swState = pll_clock_pkg::SW_RUN;
					switchDone = 1'b1;
				end
			end
		endcase
	end

	// Sequencer flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			swState <= pll_clock_pkg::SW_RUN;
			activeSrc <= pll_clock_pkg::SRC_OSC;
			oscCnt <= 2'h0;
			pclkCnt <= 2'h0;
			oscPrev <= 1'b0;
			base_clock_out <= 1'b0;
		end else begin
			swState <= next_swState;
			activeSrc <= next_activeSrc;
			oscCnt <= next_oscCnt;
			pclkCnt <= next_pclkCnt;
			oscPrev <= next_oscPrev;
			base_clock_out <= next_baseOut;
		end
	end

	// ==========================================================
	// Bus answer and registered outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			pll_reference_clock <= 1'b0;
			pllEnable <= 1'b0;
			prescaler <= 2'h0;
			vcoRangePower <= 2'h0;
			multiplier <= `ONE_N;
			linearRange <= 8'h00;
			refDivider <= `ONE_R;
			vcoCentreHz <= 32'h0000_0000;
			pll_lock_interrupt <= 1'b0;
		end else begin
			prdata <= setupPh ? rdMux : 32'h0000_0000;
			pready <= setupPh;
			pslverr <= setupPh && !mapped;
			pll_reference_clock <= oscSync;
			// Zero L keeps the PLL off
			pllEnable <= pllRun && !lZero;
			prescaler <= pre;
			vcoRangePower <= vco_range_power_field;
			multiplier <= effN;
			linearRange <= lrange;
			refDivider <= effR;
			// Centre of range from L, E and the step
			vcoCentreHz <= 32'(({24'h00_0000, lrange} << vco_range_power_field) * `FNOM_HZ);
			pll_lock_interrupt <= |(next_status & irqEn);
		end
	end

	// ==========================================================
	// Assertions
	sequence s_holdEnter;
		swState == pll_clock_pkg::SW_RUN && reqSrc != activeSrc;
	endsequence
	sequence s_holdStay;
		swState == pll_clock_pkg::SW_HOLD [*2];
	endsequence
	a_frozen_fields: assert property (@(posedge clk) disable iff (sys_rst)
		$past(pllRun) && $past(wrAcc) |-> $stable(lrange) && $stable(mulLow) && $stable(pre)
		&& $stable(mulHigh) && $stable(rdiv) && $stable(vco_range_power_field))
		else $error("divider field changed while PLL running");
	a_zero_as_one: assert property (@(posedge clk) disable iff (sys_rst)
		rdiv == 4'h0 |=> refDivider == `ONE_R)
		else $error("zero divider not treated as one");
	a_lzero_osc: assert property (@(posedge clk) disable iff (sys_rst)
		lZero |-> reqSrc == pll_clock_pkg::SRC_OSC ##1 !pllEnable)
		else $error("zero L did not force oscillator");
	a_hold_static: assert property (@(posedge clk) disable iff (sys_rst)
		s_holdEnter ##1 s_holdStay |-> $stable(base_clock_out))
		else $error("base clock moved during switch");
	a_osc_halved: assert property (@(posedge clk) disable iff (sys_rst)
		swState == pll_clock_pkg::SW_RUN && reqSrc == activeSrc && !bypass
		&& activeSrc == pll_clock_pkg::SRC_OSC && oscRise |=> base_clock_out != $past(base_clock_out))
		else $error("oscillator edge did not toggle base clock");
	a_bypass_follow: assert property (@(posedge clk) disable iff (sys_rst)
		swState == pll_clock_pkg::SW_RUN && reqSrc == activeSrc && bypass
		&& activeSrc == pll_clock_pkg::SRC_OSC |=> base_clock_out == $past(oscSync))
		else $error("bypassed oscillator not followed");
	a_sel_needs_run: assert property (@(posedge clk) disable iff (sys_rst)
		baseSel |-> pllRun && !lZero)
		else $error("VCO selected while PLL off");
	a_run_kept: assert property (@(posedge clk) disable iff (sys_rst)
		$past(baseSel) |-> pllRun)
		else $error("PLL stopped while selected");
	a_single_change: assert property (@(posedge clk) disable iff (sys_rst)
		!($changed(pllRun) && $changed(baseSel)))
		else $error("run and select changed together");
	a_lock_flag: assert property (@(posedge clk) disable iff (sys_rst)
		lockToggle |=> status[`IRQ_LOCK_BIT] && (pll_lock_interrupt || !$past(irqEn[`IRQ_LOCK_BIT])))
		else $error("lock toggle lost");
endmodule : pll_base_clock_selector

// *** hdl/pll_clock_pkg.sv ***
// Types shared by the clock selector modules
package pll_clock_pkg;
	// Switch sequencer states
	typedef enum logic [0:0] {
		SW_RUN = 1'b0,
		SW_HOLD = 1'b1
	} switch_state_t;
	// Base clock source
	typedef enum logic [0:0] {
		SRC_OSC = 1'b0,
		SRC_PCLK = 1'b1
	} clk_src_t;
endpackage : pll_clock_pkg

// *** hdl/pll_clock_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the clock selector
`ifndef PLL_CLOCK_REGS_SVH
`define PLL_CLOCK_REGS_SVH

// ==========================================================
// Register byte offsets
`define PCR_OFFSET 8'h00
`define MULLO_OFFSET 8'h04
`define MULHI_OFFSET 8'h08
`define LRANGE_OFFSET 8'h0C
`define RDIV_OFFSET 8'h10
`define OPT2_OFFSET 8'h14
`define IRQST_OFFSET 8'h18
`define IRQEN_OFFSET 8'h1C
`define IRQCLR_OFFSET 8'h20
`define STATE_OFFSET 8'h24
`define EFFDIV_OFFSET 8'h28

// ==========================================================
// Register field positions
`define PCR_VPR_MSB 1
`define PCR_VPR_LSB 0
`define PCR_PRE_MSB 3
`define PCR_PRE_LSB 2
`define PCR_SEL_BIT 4
`define PCR_RUN_BIT 5
`define PCR_FLAG_BIT 6
`define OPT2_BYPASS_BIT 0
`define IRQ_LOCK_BIT 0
`define IRQ_SWITCH_BIT 1
`define EFFDIV_N_LSB 16

// ==========================================================
// Reset values
`define MUL_RESET 12'h040
`define LRANGE_RESET 8'h01
`define RDIV_RESET 4'h1
`define ONE_N 12'h001
`define ONE_R 4'h1

// ==========================================================
// Timing and frequency figures
`define SWITCH_EDGES 2'h3
`define FNOM_HZ 32'h0000_9600

`endif

// *** verification/clock_source_model.sv ***
// Oscillator, VCO and lock detector model facing the clock selector
`timescale 1ns/1ps
module clock_source_model #(
	parameter int OSC_HALF = 6,
	parameter int VCO_HALF = 4
) (
	// Clock
	input wire logic clk,
	// Controls from selector and bench
	input wire logic pllEnable,
	input wire logic lockReq,
	// Analog side outputs
	output logic osc_clock,
	output logic vco_clock,
	output logic lockDetect
);
	// ==========================================
	// Counters for both sources, the VCO one held at zero while pllEnable is low
	int oscCnt = 0;
	int vcoCnt = 0;
	initial begin
		osc_clock = 1'b0;
		vco_clock = 1'b0;
		lockDetect = 1'b0;
	end
	always @(posedge clk) begin
		oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
		if (oscCnt == OSC_HALF - 1) begin
			osc_clock <= ~osc_clock;
		end
	end
	always @(posedge clk) begin
		vcoCnt <= (pllEnable && vcoCnt != VCO_HALF - 1) ? vcoCnt + 1 : 0;
		if (pllEnable && vcoCnt == VCO_HALF - 1) begin
			vco_clock <= ~vco_clock;
		end
	end
	always @(posedge clk) begin
		lockDetect <= lockReq;
	end
endmodule : clock_source_model

// *** verification/pll_base_clock_selector_test.sv ***
// Self-checking bench for the PLL base clock selector
`timescale 1ns/1ps
`include "pll_clock_regs.svh"
module pll_base_clock_selector_test;
	// ==========================================
	// Bench signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic lockReq = 1'b0;
	logic [31:0] prdata, vcoCentreHz;
	logic pready, pslverr, lastErr, osc_clock, vco_clock, lockDetect;
	logic base_clock_out, pll_reference_clock, pllEnable, pll_lock_interrupt;
	logic [1:0] prescaler, vcoRangePower;
	logic [11:0] multiplier;
	logic [7:0] linearRange;
	logic [3:0] refDivider;
	int fail_count = 0;
	int n_tests = 0;
	// ==========================================
	// Design and far side
	pll_base_clock_selector dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_clock(osc_clock), .vco_clock(vco_clock),
		.lockDetect(lockDetect), .base_clock_out(base_clock_out),
		.pll_reference_clock(pll_reference_clock), .pllEnable(pllEnable),
		.prescaler(prescaler), .vcoRangePower(vcoRangePower), .multiplier(multiplier),
		.linearRange(linearRange), .refDivider(refDivider), .vcoCentreHz(vcoCentreHz),
		.pll_lock_interrupt(pll_lock_interrupt));
	clock_source_model model (.clk(clk), .pllEnable(pllEnable), .lockReq(lockReq),
		.osc_clock(osc_clock), .vco_clock(vco_clock), .lockDetect(lockDetect));
	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end
	// ==========================================
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// APB transfer, held until pready is sampled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			check(32'h0, 32'h1);
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd
	// Count output and source rises over a window; div is source rises per output rise
	task automatic measure(input logic useVco, input int div);
		int b, s, r, hi, lo;
		logic pb, ps, pr, cs;
		b = 0;
		s = 0;
		r = 0;
		hi = 0;
		lo = 0;
		pb = base_clock_out;
		ps = 1'b1;
		pr = 1'b1;
		repeat (1200) begin
			@(posedge clk);
			cs = useVco ? vco_clock : osc_clock;
			b += (base_clock_out && !pb);
			s += (cs && !ps);
			r += (pll_reference_clock && !pr);
			hi += base_clock_out;
			lo += !base_clock_out;
			pb = base_clock_out;
			ps = cs;
			pr = pll_reference_clock;
		end
		check(32'((b * div + div >= s) && (s + div >= b * div) && b > 4), 32'h1);
		check(32'((hi > lo ? hi - lo : lo - hi) <= 64), 32'h1);
		check(32'(useVco || (r + 1 >= s && s + 1 >= r)), 32'h1);
	endtask : measure
	// Output frozen at first, then switch done reported
	task automatic switch_wait;
		logic [31:0] q;
		logic b0;
		int n;
		n = 0;
		q = 32'h0;
		// Last toggle may land on the edge that raised the request
		@(posedge clk);
		b0 = base_clock_out;
		repeat (20) begin
			@(posedge clk);
			check(base_clock_out, b0);
		end
		while (q[`IRQ_SWITCH_BIT] !== 1'b1 && n < 200) begin
			apb(1'b0, `IRQST_OFFSET, 32'h0, q);
			n++;
		end
		check(q[`IRQ_SWITCH_BIT], 1'b1);
		wr(`IRQCLR_OFFSET, 32'h00000002);
	endtask : switch_wait
	// Watchdog
	initial begin
		#400000;
		fail_count++;
		end_of_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`PCR_OFFSET, 32'h00000020);
		rd(`MULLO_OFFSET, 32'h00000040);
		rd(`MULHI_OFFSET, 32'h00000000);
		rd(`EFFDIV_OFFSET, 32'h00400001);
		rd(8'hFC, 32'h00000000);
		check(lastErr, 1'b1);
		// Lock interrupt raised, read back, cleared, masked
		wr(`IRQEN_OFFSET, 32'h00000001);
		lockReq <= 1'b1;
		repeat (8) @(posedge clk);
		check(pll_lock_interrupt, 1'b1);
		rd(`PCR_OFFSET, 32'h00000060);
		rd(`PCR_OFFSET, 32'h00000020);
		wr(`IRQCLR_OFFSET, 32'h00000001);
		repeat (3) @(posedge clk);
		check(pll_lock_interrupt, 1'b0);
		wr(`IRQEN_OFFSET, 32'h00000000);
		lockReq <= 1'b0;
		repeat (8) @(posedge clk);
		check(pll_lock_interrupt, 1'b0);
		rd(`IRQST_OFFSET, 32'h00000001);
		wr(`IRQCLR_OFFSET, 32'h00000001);
		rd(`PCR_OFFSET, 32'h00000020);
		// Divider fields locked while running
		wr(`MULLO_OFFSET, 32'h00000012);
		wr(`PCR_OFFSET, 32'h0000002A);
		rd(`MULLO_OFFSET, 32'h00000040);
		rd(`PCR_OFFSET, 32'h00000020);
		wr(`PCR_OFFSET, 32'h00000000);
		repeat (2) @(posedge clk);
		check(pllEnable, 1'b0);
		// Software loads P=2, E=1, zero N and R
		wr(`PCR_OFFSET, 32'h00000009);
		wr(`MULLO_OFFSET, 32'h00000000);
		wr(`MULHI_OFFSET, 32'h00000000);
		wr(`RDIV_OFFSET, 32'h00000000);
		rd(`EFFDIV_OFFSET, 32'h00010001);
		check({multiplier, refDivider}, {12'h001, 4'h1});
		check({prescaler, vcoRangePower}, 4'h9);
		wr(`MULLO_OFFSET, 32'h00000034);
		wr(`MULHI_OFFSET, 32'h00000002);
		wr(`LRANGE_OFFSET, 32'h00000010);
		repeat (2) @(posedge clk);
		check(multiplier, 12'h234);
		check(linearRange, 8'h10);
		check(vcoCentreHz, 32'h0012C000);
		// Oscillator path, halved and bypassed
		measure(1'b0, 2);
		wr(`OPT2_OFFSET, 32'h00000001);
		measure(1'b0, 1);
		wr(`OPT2_OFFSET, 32'h00000000);
		// Select refused while off, combined change refused
		wr(`PCR_OFFSET, 32'h00000019);
		rd(`PCR_OFFSET, 32'h00000009);
		wr(`PCR_OFFSET, 32'h00000039);
		rd(`PCR_OFFSET, 32'h00000009);
		wr(`PCR_OFFSET, 32'h00000029);
		wr(`PCR_OFFSET, 32'h00000039);
		switch_wait();
		rd(`STATE_OFFSET, 32'h0000000C);
		measure(1'b1, 8);
		wr(`PCR_OFFSET, 32'h00000019);
		rd(`PCR_OFFSET, 32'h00000039);
		wr(`PCR_OFFSET, 32'h00000009);
		rd(`PCR_OFFSET, 32'h00000039);
		wr(`PCR_OFFSET, 32'h00000029);
		switch_wait();
		// Zero L keeps PLL off and oscillator selected
		wr(`PCR_OFFSET, 32'h00000009);
		wr(`LRANGE_OFFSET, 32'h00000000);
		wr(`PCR_OFFSET, 32'h00000029);
		wr(`PCR_OFFSET, 32'h00000039);
		rd(`PCR_OFFSET, 32'h00000029);
		check(pllEnable, 1'b0);
		measure(1'b0, 2);
		end_of_test();
	end
endmodule : pll_base_clock_selector_test
